// ### hdl/mcu_interrupt_controller.v
// interrupt request, enable and vectoring logic of the microcontroller
// How it works
// - edge select off, rising, falling, both
// - pin1 select bits 3:2, pin0 1:0
// - unimplemented bits read zero, ignore writes
// - control 0 holds global, pin0, comparator, group0
// - control 1 holds group1/2, converter, timebase0
// - control 2 holds timebase1, pin1, serial, uart
// - group0 holds standard timer enables and flags
// - group1 holds periodic and compact timer bits
// - group2 holds low supply and nvm bits
// - events set flags regardless of enables
// - vector only when own enable set
// - global enable low blocks all interrupts
// - push return address, load vector address
// - core fetches next instruction from vector
// - return pops saved program counter
// - group flag set when any source sets
// - service clears global enable, flags latch
// - service clears serviced primary flag only
// - no acknowledge while stack is full
`default_nettype none
module mcu_interrupt_controller #(
   parameter PC_W = 13
) (
   input  wire            i_clk,
   input  wire            i_rst_n,
   input  wire [2:0]      i_reg_addr,
   input  wire            i_reg_wr,
   input  wire [7:0]      i_reg_wdata,
   output reg  [7:0]      o_reg_rdata,
   input  wire            i_ext_pin_0,
   input  wire            i_ext_pin_1,
   input  wire            i_comparator_evt,
   input  wire            i_converter_evt,
   input  wire            i_timebase0_evt,
   input  wire            i_timebase1_evt,
   input  wire            i_serial_module_evt,
   input  wire            i_uart_evt,
   input  wire            i_std_timer_period_evt,
   input  wire            i_std_timer_cmpa_evt,
   input  wire            i_periodic_timer_period_evt,
   input  wire            i_periodic_timer_cmpa_evt,
   input  wire            i_compact_timer_period_evt,
   input  wire            i_compact_timer_cmpa_evt,
   input  wire            i_low_supply_evt,
   input  wire            i_nvm_write_evt,
   input  wire            i_insn_boundary,
   input  wire [PC_W-1:0] i_next_pc,
   input  wire            i_stack_full,
   input  wire            i_return_from_interrupt,
   input  wire [PC_W-1:0] i_stack_top,
   output reg             o_irq_take,
   output reg  [3:0]      o_irq_id,
   output reg  [PC_W-1:0] o_push_pc,
   output reg             o_push,
   output reg             o_pop,
   output reg             o_pc_load,
   output reg  [PC_W-1:0] o_pc_value
);
`include "irq_ctrl_regs.vh"
   localparam NSRC = 11;

   reg [7:0] edge_cfg_r;
   reg [7:0] ctrl0_r;
   reg [7:0] ctrl1_r;
   reg [7:0] ctrl2_r;
   reg [7:0] grp0_r;
   reg [7:0] grp1_r;
   reg [7:0] grp2_r;
   reg [7:0] ctrl0_nxt;
   reg [7:0] ctrl1_nxt;
   reg [7:0] ctrl2_nxt;
   reg [7:0] grp0_nxt;
   reg [7:0] grp1_nxt;
   reg [7:0] grp2_nxt;

   wire pin0_evt;
   wire pin1_evt;
   reg  sync_cmp0_r, sync_cmp1_r;

   edge_detect u_pin0 (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_ext_pin_0),
      .i_sel   (edge_cfg_r[`PIN0_SEL_LSB+1:`PIN0_SEL_LSB]),
      .o_event (pin0_evt)
   );
   edge_detect u_pin1 (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_ext_pin_1),
      .i_sel   (edge_cfg_r[`PIN1_SEL_LSB+1:`PIN1_SEL_LSB]),
      .o_event (pin1_evt)
   );

   // write selector shared by all registers
   function wr_hit;
      input [2:0] a;
      input       w;
      input [2:0] target;
      begin
         wr_hit = w & (a == target);
      end
   endfunction

   // priority table: index 0 highest; flag and enable of each primary source
   // order pin0, comparator, group0, group1, group2, converter, tb0, tb1, pin1, serial, uart
   wire [NSRC-1:0] src_flag;
   wire [NSRC-1:0] src_en;
   assign src_flag = {ctrl2_r[7], ctrl2_r[6], ctrl2_r[5], ctrl2_r[4], ctrl1_r[7], ctrl1_r[6],
                      ctrl1_r[5], ctrl1_r[4], ctrl0_r[6], ctrl0_r[5], ctrl0_r[4]};
   assign src_en   = {ctrl2_r[3], ctrl2_r[2], ctrl2_r[1], ctrl2_r[0], ctrl1_r[3], ctrl1_r[2],
                      ctrl1_r[1], ctrl1_r[0], ctrl0_r[3], ctrl0_r[2], ctrl0_r[1]};

   wire [NSRC-1:0] pend = src_flag & src_en;
   wire            can_take = ctrl0_r[`GLOBAL_EN_BIT] & ~i_stack_full & i_insn_boundary
                              & ~o_irq_take & (|pend);

   reg [3:0]       grant_idx;
   reg [NSRC-1:0]  grant_1h;
   integer         k;
   always @* begin
      grant_idx = 4'h0;
      grant_1h  = {NSRC{1'b0}};
      for (k = NSRC-1; k >= 0; k = k - 1) begin
         if (pend[k]) begin
            grant_idx = k[3:0];
            grant_1h  = {NSRC{1'b0}};
            grant_1h[k] = 1'b1;
         end
      end
   end
   wire [NSRC-1:0] clr = can_take ? grant_1h : {NSRC{1'b0}};

   // shared-group summary events from source flags rising
   wire grp0_any = |(grp0_nxt[5:4] & ~grp0_r[5:4]);
   wire grp1_any = |(grp1_nxt[7:4] & ~grp1_r[7:4]);
   wire grp2_any = |(grp2_nxt[5:4] & ~grp2_r[5:4]);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_cmp0_r <= 1'b0;
         sync_cmp1_r <= 1'b0;
      end else begin
         sync_cmp0_r <= i_comparator_evt;
         sync_cmp1_r <= sync_cmp0_r;
      end
   end

   // next values: software write, then hardware clear, then hardware set (set wins)
   always @* begin
      grp0_nxt = grp0_r;
      grp1_nxt = grp1_r;
      grp2_nxt = grp2_r;
      if (wr_hit(i_reg_addr, i_reg_wr, `ADDR_SHARED_GROUP_CTRL_0))
         grp0_nxt = i_reg_wdata & `SHARED0_MASK;
      if (wr_hit(i_reg_addr, i_reg_wr, `ADDR_SHARED_GROUP_CTRL_1))
         grp1_nxt = i_reg_wdata & `SHARED1_MASK;
      if (wr_hit(i_reg_addr, i_reg_wr, `ADDR_SHARED_GROUP_CTRL_2))
         grp2_nxt = i_reg_wdata & `SHARED2_MASK;
      // source flags are only cleared by software writes
      grp0_nxt[4] = grp0_nxt[4] | i_std_timer_period_evt;
      grp0_nxt[5] = grp0_nxt[5] | i_std_timer_cmpa_evt;
      grp1_nxt[4] = grp1_nxt[4] | i_periodic_timer_period_evt;
      grp1_nxt[5] = grp1_nxt[5] | i_periodic_timer_cmpa_evt;
      grp1_nxt[6] = grp1_nxt[6] | i_compact_timer_period_evt;
      grp1_nxt[7] = grp1_nxt[7] | i_compact_timer_cmpa_evt;
      grp2_nxt[4] = grp2_nxt[4] | i_low_supply_evt;
      grp2_nxt[5] = grp2_nxt[5] | i_nvm_write_evt;

      ctrl0_nxt = ctrl0_r;
      ctrl1_nxt = ctrl1_r;
      ctrl2_nxt = ctrl2_r;
      if (wr_hit(i_reg_addr, i_reg_wr, `ADDR_PRIMARY_IRQ_CTRL_0))
         ctrl0_nxt = i_reg_wdata & `CTRL0_MASK;
      if (wr_hit(i_reg_addr, i_reg_wr, `ADDR_PRIMARY_IRQ_CTRL_1))
         ctrl1_nxt = i_reg_wdata & `CTRL1_MASK;
      if (wr_hit(i_reg_addr, i_reg_wr, `ADDR_PRIMARY_IRQ_CTRL_2))
         ctrl2_nxt = i_reg_wdata & `CTRL2_MASK;
      if (can_take)
         ctrl0_nxt[`GLOBAL_EN_BIT] = 1'b0;
      ctrl0_nxt[4] = (ctrl0_nxt[4] & ~clr[0]) | pin0_evt;
      ctrl0_nxt[5] = (ctrl0_nxt[5] & ~clr[1]) | (sync_cmp1_r);
      ctrl0_nxt[6] = (ctrl0_nxt[6] & ~clr[2]) | grp0_any;
      ctrl1_nxt[4] = (ctrl1_nxt[4] & ~clr[3]) | grp1_any;
      ctrl1_nxt[5] = (ctrl1_nxt[5] & ~clr[4]) | grp2_any;
      ctrl1_nxt[6] = (ctrl1_nxt[6] & ~clr[5]) | i_converter_evt;
      ctrl1_nxt[7] = (ctrl1_nxt[7] & ~clr[6]) | i_timebase0_evt;
      ctrl2_nxt[4] = (ctrl2_nxt[4] & ~clr[7]) | i_timebase1_evt;
      ctrl2_nxt[5] = (ctrl2_nxt[5] & ~clr[8]) | pin1_evt;
      ctrl2_nxt[6] = (ctrl2_nxt[6] & ~clr[9]) | i_serial_module_evt;
      ctrl2_nxt[7] = (ctrl2_nxt[7] & ~clr[10]) | i_uart_evt;
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         edge_cfg_r <= `REG_RESET;
         ctrl0_r    <= `REG_RESET;
         ctrl1_r    <= `REG_RESET;
         ctrl2_r    <= `REG_RESET;
         grp0_r     <= `REG_RESET;
         grp1_r     <= `REG_RESET;
         grp2_r     <= `REG_RESET;
      end else begin
         if (wr_hit(i_reg_addr, i_reg_wr, `ADDR_EXT_EDGE_CONFIG))
            edge_cfg_r <= i_reg_wdata & `EDGE_CFG_MASK;
         ctrl0_r <= ctrl0_nxt;
         ctrl1_r <= ctrl1_nxt;
         ctrl2_r <= ctrl2_nxt;
         grp0_r  <= grp0_nxt;
         grp1_r  <= grp1_nxt;
         grp2_r  <= grp2_nxt;
      end
   end

   // registered read data
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
      end else begin
         case (i_reg_addr)
            `ADDR_EXT_EDGE_CONFIG:     o_reg_rdata <= edge_cfg_r;
            `ADDR_PRIMARY_IRQ_CTRL_0:  o_reg_rdata <= ctrl0_r;
            `ADDR_PRIMARY_IRQ_CTRL_1:  o_reg_rdata <= ctrl1_r;
            `ADDR_PRIMARY_IRQ_CTRL_2:  o_reg_rdata <= ctrl2_r;
            `ADDR_SHARED_GROUP_CTRL_0: o_reg_rdata <= grp0_r;
            `ADDR_SHARED_GROUP_CTRL_1: o_reg_rdata <= grp1_r;
            `ADDR_SHARED_GROUP_CTRL_2: o_reg_rdata <= grp2_r;
            default:                   o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // core-facing strobes
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq_take <= 1'b0;
         o_irq_id   <= 4'h0;
         o_push_pc  <= {PC_W{1'b0}};
         o_push     <= 1'b0;
         o_pop      <= 1'b0;
         o_pc_load  <= 1'b0;
         o_pc_value <= {PC_W{1'b0}};
      end else begin
         o_irq_take <= can_take;
         o_push     <= can_take;
         o_pop      <= 1'b0;
         o_pc_load  <= 1'b0;
         if (can_take) begin
            o_irq_id   <= grant_idx;
            o_push_pc  <= i_next_pc;
            o_pc_load  <= 1'b1;
            o_pc_value <= `VECTOR_BASE + {{(PC_W-4){1'b0}}, grant_idx} * `VECTOR_STEP;
         end else if (i_return_from_interrupt) begin
            o_pop      <= 1'b1;
            o_pc_load  <= 1'b1;
            o_pc_value <= i_stack_top;
         end
      end
   end
endmodule // mcu_interrupt_controller
`default_nettype wire

// ### hdl/irq_ctrl_regs.vh
// register addresses, field positions and reset values of the interrupt controller
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH
`define ADDR_EXT_EDGE_CONFIG     3'h0
`define ADDR_PRIMARY_IRQ_CTRL_0  3'h1
`define ADDR_PRIMARY_IRQ_CTRL_1  3'h2
`define ADDR_PRIMARY_IRQ_CTRL_2  3'h3
`define ADDR_SHARED_GROUP_CTRL_0 3'h4
`define ADDR_SHARED_GROUP_CTRL_1 3'h5
`define ADDR_SHARED_GROUP_CTRL_2 3'h6
`define REG_RESET                8'h00
`define EDGE_CFG_MASK            8'h0f
`define CTRL0_MASK               8'h7f
`define CTRL1_MASK               8'hff
`define CTRL2_MASK               8'hff
`define SHARED0_MASK             8'h33
`define SHARED1_MASK             8'hff
`define SHARED2_MASK             8'h33
`define PIN0_SEL_LSB             0
`define PIN1_SEL_LSB             2
`define EDGE_OFF                 2'b00
`define EDGE_RISE                2'b01
`define EDGE_FALL                2'b10
`define EDGE_BOTH                2'b11
`define GLOBAL_EN_BIT            0
`define VECTOR_BASE              13'h0004
`define VECTOR_STEP              13'h0004
`endif

// ### hdl/edge_detect.v
// synchronised external pin with selectable edge detection
`default_nettype none
module edge_detect (
   input  wire       i_clk,
   input  wire       i_rst_n,
   input  wire       i_pin,
   input  wire [1:0] i_sel,
   output reg        o_event
);
`include "irq_ctrl_regs.vh"
   reg sync0_r;
   reg sync1_r;
   reg prev_r;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync0_r <= 1'b0;
         sync1_r <= 1'b0;
         prev_r  <= 1'b0;
         o_event <= 1'b0;
      end else begin
         sync0_r <= i_pin;
         sync1_r <= sync0_r;
         prev_r  <= sync1_r;
         case (i_sel)
            `EDGE_RISE: o_event <= sync1_r & ~prev_r;
            `EDGE_FALL: o_event <= ~sync1_r & prev_r;
            `EDGE_BOTH: o_event <= sync1_r ^ prev_r;
            default:    o_event <= 1'b0;
         endcase
      end
   end
endmodule // edge_detect
`default_nettype wire

// ### dv/irq_ctrl_chk.sv
// port-level assertions for the interrupt controller
`default_nettype none
module irq_ctrl_chk #(
   parameter int PC_W = 13
) (
   input wire logic            i_clk,
   input wire logic            i_rst_n,
   input wire logic [2:0]      i_reg_addr,
   input wire logic            i_reg_wr,
   input wire logic [7:0]      o_reg_rdata,
   input wire logic            i_insn_boundary,
   input wire logic            i_stack_full,
   input wire logic            i_return_from_interrupt,
   input wire logic [PC_W-1:0] i_stack_top,
   input wire logic            o_irq_take,
   input wire logic [3:0]      o_irq_id,
   input wire logic            o_push,
   input wire logic            o_pop,
   input wire logic            o_pc_load,
   input wire logic [PC_W-1:0] o_pc_value
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // a grant cycle and the cycle after it, both without any register write
   sequence s_served;
      (o_irq_take && !i_reg_wr) ##1 !i_reg_wr;
   endsequence
   a_take_strobes: assert property (o_irq_take |-> o_push && o_pc_load)
      else $error("grant without push or load");
   a_take_gap: assert property (o_irq_take |=> !o_irq_take)
      else $error("grants back to back");
   a_vec_addr: assert property (o_irq_take |-> o_pc_value == (PC_W'(o_irq_id) + 1) * 4)
      else $error("wrong vector address");
   a_grant_gate: assert property (o_irq_take |-> !$past(i_stack_full) && $past(i_insn_boundary))
      else $error("grant while stack full");
   a_no_nest: assert property (s_served |=> !o_irq_take)
      else $error("nested grant without enable");
   a_pop_resume: assert property (o_pop |-> o_pc_load && o_pc_value == $past(i_stack_top)
      && $past(i_return_from_interrupt))
      else $error("return did not resume");
   a_edge_hole: assert property ($past(i_reg_addr) == 3'h0 |-> o_reg_rdata[7:4] == 4'h0)
      else $error("edge config high bits set");
   a_unmapped_zero: assert property ($past(i_reg_addr) == 3'h7 |-> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule // irq_ctrl_chk
`default_nettype wire

// ### dv/core_stack.sv
// core model: return stack fed by push and pop strobes
`default_nettype none
module core_stack #(
   parameter int PC_W  = 13,
   parameter int DEPTH = 2
) (
   input wire logic             i_clk,
   input wire logic             i_rst_n,
   input wire logic             i_push,
   input wire logic [PC_W-1:0]  i_push_pc,
   input wire logic             i_pop,
   output logic     [PC_W-1:0]  o_top,
   output logic                 o_full
);
   logic [PC_W-1:0] mem [DEPTH];
   int              sp_r;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sp_r <= 0;
      end else if (i_push && sp_r < DEPTH) begin
         mem[sp_r] <= i_push_pc;
         sp_r <= sp_r + 1;
      end else if (i_pop && sp_r > 0) begin
         sp_r <= sp_r - 1;
      end
   end
   // empty stack shows a pattern, not a stale entry
   assign o_top  = (sp_r > 0) ? mem[sp_r-1] : {PC_W{1'b1}};
   assign o_full = (sp_r >= DEPTH);
endmodule // core_stack
`default_nettype wire

// ### dv/mcu_interrupt_controller_test.sv
// self-checking bench for the interrupt controller
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module mcu_interrupt_controller_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PC_W = 13;
   logic            i_clk = 0, i_rst_n = 0, wr = 0, bnd = 0, ret = 0, pin = 0;
   logic [2:0]      addr = 0;
   logic [7:0]      wd = 0;
   logic [13:0]     ev = 0;
   logic [PC_W-1:0] npc = 0;
   wire logic [7:0] rdata;
   wire logic [3:0] id;
   wire logic [PC_W-1:0] ppc, pcv, top;
   wire logic       take, push, pop, pld, full;
   int num_errors = 0, n_tests = 0, takes = 0, cyc = 0;
   logic [7:0]  msk [8] = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'h33, 8'hff, 8'h33, 8'h00};
   // event index, register, expected flags
   logic [15:0] rows [14] = '{16'h0120, 16'h1240, 16'h2280, 16'h3310, 16'h4340, 16'h5380, 16'h6410,
      16'h7420, 16'h8510, 16'h9520, 16'ha540, 16'hb580, 16'hc610, 16'hd620};
   always #25 i_clk = ~i_clk;
   mcu_interrupt_controller #(.PC_W(PC_W)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_ext_pin_0(pin), .i_ext_pin_1(pin), .i_comparator_evt(ev[0]),
      .i_converter_evt(ev[1]), .i_timebase0_evt(ev[2]), .i_timebase1_evt(ev[3]), .i_serial_module_evt(ev[4]),
      .i_uart_evt(ev[5]), .i_std_timer_period_evt(ev[6]), .i_std_timer_cmpa_evt(ev[7]),
      .i_periodic_timer_period_evt(ev[8]), .i_periodic_timer_cmpa_evt(ev[9]), .i_compact_timer_period_evt(ev[10]),
      .i_compact_timer_cmpa_evt(ev[11]), .i_low_supply_evt(ev[12]), .i_nvm_write_evt(ev[13]), .i_insn_boundary(bnd),
      .i_next_pc(npc), .i_stack_full(full), .i_return_from_interrupt(ret), .i_stack_top(top), .o_irq_take(take),
      .o_irq_id(id), .o_push_pc(ppc), .o_push(push), .o_pop(pop), .o_pc_load(pld), .o_pc_value(pcv));
   core_stack #(.PC_W(PC_W), .DEPTH(2)) u_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_push(push),
      .i_push_pc(ppc), .i_pop(pop), .o_top(top), .o_full(full));
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk); addr <= a; wd <= d; wr <= 1'b1;
      @(posedge i_clk); wr <= 1'b0;
   endtask
   task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge i_clk); addr <= a;
      @(posedge i_clk); #1;
      `CHK(rdata, e)
   endtask
   task automatic fire(input logic [3:0] i);
      @(posedge i_clk); ev <= 14'h1 << i;
      @(posedge i_clk); ev <= 14'h0;
      repeat (3) @(posedge i_clk);
   endtask
   // clears both pin flags, then moves the pins and lets the synchroniser settle
   task automatic pins(input logic v);
      wr_reg(3'h1, 8'h00);
      wr_reg(3'h3, 8'h00);
      @(posedge i_clk); pin <= v;
      repeat (4) @(posedge i_clk);
   endtask
   task automatic wait_take(input logic [3:0] e_id, input logic [PC_W-1:0] e_pc);
      int k;
      k = 0;
      do begin
         @(posedge i_clk); #1;
         k++;
      end while (take !== 1'b1 && k < 20);
      `CHK(take, 1'b1)
      `CHK(pld, 1'b1)
      `CHK(id, e_id)
      `CHK(pcv, (PC_W'(e_id) + 13'h1) * 13'h4)
      `CHK(ppc, e_pc)
   endtask
   task automatic do_ret(input logic [PC_W-1:0] e);
      @(posedge i_clk); ret <= 1'b1;
      @(posedge i_clk); ret <= 1'b0; #1;
      `CHK(pop, 1'b1)
      `CHK(pcv, e)
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (take === 1'b1) takes++;
      if (cyc == 4000) begin
         num_errors++;
         wrap_up;
      end
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int a = 0; a < 8; a++) chk_reg(3'(a), 8'h00);
      for (int d = 0; d < 2; d++)
         for (int a = 0; a < 8; a++) begin
            wr_reg(3'(a), d ? 8'h00 : 8'hff);
            chk_reg(3'(a), d ? 8'h00 : msk[a]);
         end
      foreach (rows[i]) begin
         fire(rows[i][15:12]);
         chk_reg(rows[i][10:8], rows[i][7:0]);
         wr_reg(rows[i][10:8], 8'h00);
      end
      for (int s = 0; s < 4; s++) begin
         wr_reg(3'h0, 8'(s * 5));
         pins(1'b1);
         chk_reg(3'h1, s[0] ? 8'h10 : 8'h00);
         chk_reg(3'h3, s[0] ? 8'h20 : 8'h00);
         pins(1'b0);
         chk_reg(3'h1, s[1] ? 8'h10 : 8'h00);
         chk_reg(3'h3, s[1] ? 8'h20 : 8'h00);
      end
      @(posedge i_clk); bnd <= 1'b1; npc <= 13'h123;
      wr_reg(3'h2, 8'h00);
      fire(4'h1);
      wr_reg(3'h1, 8'h01);
      repeat (3) @(posedge i_clk);
      `CHK(takes, 0)
      chk_reg(3'h2, 8'h40);
      wr_reg(3'h1, 8'h00);
      wr_reg(3'h2, 8'h44);
      repeat (3) @(posedge i_clk);
      `CHK(takes, 0)
      wr_reg(3'h1, 8'h01);
      wait_take(4'h5, 13'h123);
      chk_reg(3'h1, 8'h00);
      chk_reg(3'h2, 8'h04);
      @(posedge i_clk); npc <= 13'h0aa;
      wr_reg(3'h4, 8'h01);
      fire(4'h6);
      chk_reg(3'h1, 8'h40);
      wr_reg(3'h1, 8'h49);
      wait_take(4'h2, 13'h0aa);
      chk_reg(3'h4, 8'h11);
      chk_reg(3'h1, 8'h08);
      @(posedge i_clk); npc <= 13'h055;
      wr_reg(3'h0, 8'h01);
      pins(1'b1);
      fire(4'h5);
      wr_reg(3'h3, 8'h88);
      wr_reg(3'h1, 8'h13);
      repeat (4) @(posedge i_clk);
      `CHK(takes, 2)
      do_ret(13'h0aa);
      wait_take(4'h0, 13'h055);
      do_ret(13'h055);
      wr_reg(3'h1, 8'h01);
      wait_take(4'ha, 13'h055);
      wrap_up;
   end
endmodule // mcu_interrupt_controller_test
bind mcu_interrupt_controller irq_ctrl_chk #(.PC_W(PC_W)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .o_reg_rdata(o_reg_rdata), .i_insn_boundary(i_insn_boundary),
   .i_stack_full(i_stack_full), .i_return_from_interrupt(i_return_from_interrupt), .i_stack_top(i_stack_top),
   .o_irq_take(o_irq_take), .o_irq_id(o_irq_id), .o_push(o_push), .o_pop(o_pop), .o_pc_load(o_pc_load),
   .o_pc_value(o_pc_value));
`default_nettype wire
